// *** bench/buffer_module_output_and_panel_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module buffer_module_output_and_panel_tb;
  localparam int unsigned SC = 8;
  logic clk = 1'b0, lclk = 1'b0, rst_b = 1'b0, sel, obit, lrdy = 1'b1;
  logic ins_i = 1'b0, ins_d = 1'b0, pwe = 1'b0, jwe = 1'b0, sadv = 1'b0, shold = 1'b0;
  logic start = 1'b0, hsw = 1'b0, phr = 1'b0, derr = 1'b0, ierr = 1'b0;
  logic [7:0] code = 8'h00;
  logic [1:0] msel = 2'h2;
  logic [2:0] dsel = 3'h3;
  logic rdy, gate, done, lstb, pwr, jwr, clr, pon, stl, hl, hs, nl, del, iel;
  logic [7:0] lchr, disp;
  logic [8:0] pcode;
  logic [7:0] lq[$];
  int bad_count = 0;
  int n_checks = 0;
  always #25 clk = ~clk;
  initial
  begin
    #7;
    forever #40 lclk = ~lclk;
  end
  always @(negedge clk) if (lstb === 1'b1) lq.push_back(lchr);
  buffer_module_output_and_panel #(.STARTUP_CYC(SC), .MOD_ID(2)) i_buffer_module_output_and_panel (
    .i_clk(clk), .i_rst_b(rst_b), .i_lclk(lclk), .i_out_select(sel), .i_out_bit(obit),
    .i_link_ready(lrdy), .i_code(code), .i_ins_instr(ins_i), .i_ins_data(ins_d),
    .i_prog_wr_en(pwe), .i_jump_wr_en(jwe), .i_step_adv(sadv), .i_step_hold(shold),
    .i_start(start), .i_halt_sw(hsw), .i_prog_halt_req(phr), .i_mod_sel(msel),
    .i_disp_sel(dsel), .i_dev_err(derr), .i_int_err(ierr), .o_out_ready(rdy),
    .o_clk_gate(gate), .o_done(done), .o_link_char(lchr), .o_link_stb(lstb),
    .o_panel_code(pcode), .o_prog_wr(pwr), .o_jump_wr(jwr), .o_clear_lamp(clr),
    .o_power_lamp(pon), .o_start_lamp(stl), .o_halt_lamp(hl), .o_halt_sense(hs),
    .o_normal_lamp(nl), .o_display(disp), .o_dev_err_lamp(del), .o_int_err_lamp(iel));
  cpu_model i_cpu_model (.i_clk(clk), .i_lclk(lclk), .i_ready(rdy), .i_gate(gate),
    .i_done(done), .o_select(sel), .o_bit(obit));
  // ****************************************
  // helpers
  // ****************************************
  task automatic report_and_stop();
    if (bad_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // panel inputs pass two sync stages, so hold each press for several cycles
  task automatic press(input int k);
    @(posedge clk);
    ins_i <= (k == 0);
    ins_d <= (k == 1);
    start <= (k == 2);
    cyc(6);
    {ins_i, ins_d, start} <= 3'h0;
    cyc(6);
  endtask : press
  task automatic msg(input int n, input int abort_at, input bit badp, input bit stall);
    logic [8:0] q[$];
    logic [7:0] d;
    logic ok;
    lq.delete();
    lrdy <= ~stall;
    for (int i = 0; i < n; i++)
    begin
      d = 8'($urandom_range(254, 0));
      q.push_back({~^d, d});
    end
    q.push_back(badp ? {^bufmod_pkg::EOM_CODE, bufmod_pkg::EOM_CODE}
                     : {~^bufmod_pkg::EOM_CODE, bufmod_pkg::EOM_CODE});
    i_cpu_model.send(q, abort_at, ok);
    cyc(8);
    if (abort_at >= 0 || badp) check(9'(rdy), 9'h1);
    else
    begin
      check(9'(ok), 9'h1);
      if (stall) check(9'(lq.size()), 9'h0);
      lrdy <= 1'b1;
      for (int i = 0; i < 600 && rdy !== 1'b1; i++) cyc(1);
      check(9'(rdy), 9'h1);
      for (int i = 0; i < n; i++) check(9'(lq[i]), 9'(q[i][7:0]));
    end
  endtask : msg
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    void'($urandom(63));
    cyc(20);
    check({7'h0, rdy, clr}, 9'h0);
    @(posedge clk);
    rst_b <= 1'b1;
    cyc(2);
    check({7'h0, clr, pon}, 9'h2);
    cyc(SC + 4);
    check({5'h0, clr, pon, hl, rdy}, 9'h7);
    check(9'(disp), 9'h0);
    for (int i = 0; i < 12; i++)
    begin
      @(posedge clk);
      code <= 8'($urandom);
      msel <= 2'($urandom);
      {pwe, jwe, sadv, shold, derr, ierr} <= 6'($urandom);
      dsel <= 3'h4;
      cyc(6);
      check(pcode, {~^code, code});
      check(9'(disp), (msel == 2'h2) ? 9'(code) : 9'h0);
      check({7'h0, pwr, jwr}, (msel == 2'h2) ? {7'h0, pwe, jwe} : 9'h0);
      check({7'h0, del, iel}, {7'h0, derr, ierr});
      if (msel == 2'h2) check(9'(nl), 9'(!(sadv || shold)));
    end
    {msel, pwe, jwe, sadv, shold, derr, ierr} <= 8'h80;
    code <= 8'($urandom);
    press(0);
    dsel <= 3'h0;
    cyc(4);
    check(9'(disp), 9'(code));
    code <= 8'($urandom);
    press(1);
    dsel <= 3'h1;
    cyc(4);
    check(9'(disp), 9'(code));
    dsel <= 3'h3;
    sadv <= 1'b1;
    press(2);
    cyc(10);
    check({7'h0, disp[0], hl}, 9'h3);
    {sadv, shold} <= 2'h1;
    press(2);
    cyc(10);
    check({7'h0, disp[0], hl}, 9'h3);
    shold <= 1'b0;
    press(2);
    check({6'h0, stl, hl, hs}, 9'h4);
    {hsw, phr} <= 2'h3;
    cyc(10);
    check({6'h0, stl, hl, hs}, 9'h3);
    {hsw, phr} <= 2'h0;
    msg(3, -1, 1'b0, 1'b0);
    msg(0, -1, 1'b0, 1'b0);
    msg(3, -1, 1'b0, 1'b1);
    msg(3, 1, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) msg(int'($urandom_range(3, 1)), -1, 1'b0, 1'b0);
    msg(2, -1, 1'b1, 1'b0);
    report_and_stop();
  end
  initial
  begin
    #2_000_000;
    bad_count++;
    report_and_stop();
  end
endmodule : buffer_module_output_and_panel_tb
`default_nettype wire

// *** bench/cpu_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// processor side of the output transfer
// ****************************************
module cpu_model (
  input  wire logic i_clk,
  input  wire logic i_lclk,
  input  wire logic i_ready,
  input  wire logic i_gate,
  input  wire logic i_done,
  output var logic  o_select,
  output var logic  o_bit
);
  initial o_select = 1'b0;
  initial o_bit = 1'b0;
  // abort_at >= 0 drops select before that character is shifted
  task automatic send(input logic [8:0] q[$], input int abort_at, output logic ok);
    int t;
    ok = 1'b0;
    t = 0;
    while (i_ready !== 1'b1 && t < 4000)
    begin
      @(posedge i_clk);
      t++;
    end
    @(posedge i_clk);
    o_select <= i_ready;
    t = 0;
    // watch the gate on the link clock: the receiver needs two of its edges to see it
    while (i_gate !== 1'b1 && t < 50)
    begin
      @(posedge i_lclk);
      t++;
    end
    @(posedge i_lclk);
    foreach (q[i])
    begin
      if (i == abort_at) break;
      for (int b = 0; b < 9; b++)
      begin
        @(negedge i_lclk);
        o_bit <= q[i][b];
      end
    end
    // line no longer held: show the inverse so a stale sample is caught
    @(negedge i_lclk);
    o_bit <= ~o_bit;
    // keep toggling while waiting, so idle bits never form an end character
    t = 0;
    while (abort_at < 0 && i_done !== 1'b1 && t < 12)
    begin
      @(negedge i_lclk);
      o_bit <= ~o_bit;
      t++;
    end
    ok = (i_done === 1'b1) && (i_ready === 1'b0);
    @(posedge i_clk);
    o_select <= 1'b0;
  endtask : send
endmodule : cpu_model
`default_nettype wire

// *** inc/bufmod_pkg.sv ***
package bufmod_pkg;
  // ****************************************
  // widths and counts
  // ****************************************
  localparam int unsigned CODE_W      = 8;
  localparam int unsigned MOD_N       = 4;
  localparam int unsigned SEL_W       = 2;
  localparam int unsigned PTR_W       = 8;
  localparam int unsigned DISP_N      = 5;
  localparam int unsigned DISP_W      = 3;
  // end-of-message character code; a plain default
  localparam logic [7:0]  EOM_CODE    = 8'hff;
  localparam logic [7:0]  CODE_ZERO   = 8'h00;
  localparam logic [8:0]  CHAR9_ZERO  = 9'h000;
  localparam logic [3:0]  BITCNT_ZERO = 4'h0;
  localparam logic [3:0]  BITCNT_LAST = 4'h8;
  localparam logic [3:0]  BITCNT_ONE  = 4'h1;
  localparam logic [7:0]  PTR_ZERO    = 8'h00;
  localparam logic [7:0]  PTR_ONE     = 8'h01;
  // ****************************************
  // startup delay
  // ****************************************
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned STARTUP_US   = 1000;
  localparam int unsigned STARTUP_CYC  = (STARTUP_US * (CLK_HZ / 1_000_000));
  // ****************************************
  // display selections
  // ****************************************
  localparam logic [2:0] DSP_INSTR = 3'h0;
  localparam logic [2:0] DSP_HOLD  = 3'h1;
  localparam logic [2:0] DSP_CHAR  = 3'h2;
  localparam logic [2:0] DSP_PTR   = 3'h3;
  localparam logic [2:0] DSP_CODE  = 3'h4;
  // ****************************************
  // output message and run control states
  // ****************************************
  typedef enum logic [1:0]
  {
    OUT_IDLE  = 2'b00,
    OUT_READY = 2'b01,
    OUT_MOVE  = 2'b11,
    OUT_SEND  = 2'b10
  } out_state_t;
  typedef enum logic [1:0]
  {
    RUN_CLEAR = 2'b00,
    RUN_HALT  = 2'b01,
    RUN_EXEC  = 2'b11,
    RUN_STEP  = 2'b10
  } run_state_t;
endpackage : bufmod_pkg

// *** logic/bit_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module bit_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  typedef struct packed
  {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;
  sync_t st_q;
  sync_t st_d;
  // first stage feeds only the second stage
  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = i_d;
    st_d.s2 = st_q.s1;
  end
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      st_q <= '0;
    else
      st_q <= st_d;
  end
  assign o_q = st_q.s2;
endmodule : bit_sync
`default_nettype wire

// *** logic/buffer_module_output_and_panel.sv ***
`timescale 1ns/100ps
`default_nettype none
// Contract
// - ready rises only once the previous message has fully gone out
// - module polls select and starts a block move when true
// - module gives its clock; processor shifts bits in at that rate
// - end character with good parity sets the done flag
// - done flag drops the ready line
// - select dropped before done keeps ready high for a resend
// - with ready low, stored characters go out one by one
// - after the last character goes out, ready is set again
// - general clear halts, clears registers, resets marks; clear then operational lamp
// - eight code switches plus an automatic parity ninth bit
// - program and jump tracks each write only while their latch is on
// - insert instruction loads code into the lower instruction rank
// - insert data loads code into the track data holder
// - step advance: start executes one, fetches next, advances pointer
// - hold step: start re-executes held instruction, no fetch
// - start begins execution at the pointer; start lamp lit while running
// - halt latch readable by program, enables conditional halt; lamp when halted
// - selector routes panel functions to one of four modules
// - normal lamp only when neither step setting is on
// - display shows eight data bits of the chosen register
// - device and internal error flags each drive a lamp
module buffer_module_output_and_panel #(
  parameter int unsigned STARTUP_CYC = bufmod_pkg::STARTUP_CYC,
  parameter int unsigned MOD_ID      = 0
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_lclk,
  input  wire logic       i_out_select,
  input  wire logic       i_out_bit,
  input  wire logic       i_link_ready,
  input  wire logic [7:0] i_code,
  input  wire logic       i_ins_instr,
  input  wire logic       i_ins_data,
  input  wire logic       i_prog_wr_en,
  input  wire logic       i_jump_wr_en,
  input  wire logic       i_step_adv,
  input  wire logic       i_step_hold,
  input  wire logic       i_start,
  input  wire logic       i_halt_sw,
  input  wire logic       i_prog_halt_req,
  input  wire logic [1:0] i_mod_sel,
  input  wire logic [2:0] i_disp_sel,
  input  wire logic       i_dev_err,
  input  wire logic       i_int_err,
  output logic            o_out_ready,
  output logic            o_clk_gate,
  output logic            o_done,
  output logic [7:0]      o_link_char,
  output logic            o_link_stb,
  output logic [8:0]      o_panel_code,
  output logic            o_prog_wr,
  output logic            o_jump_wr,
  output logic            o_clear_lamp,
  output logic            o_power_lamp,
  output logic            o_start_lamp,
  output logic            o_halt_lamp,
  output logic            o_halt_sense,
  output logic            o_normal_lamp,
  output logic [7:0]      o_display,
  output logic            o_dev_err_lamp,
  output logic            o_int_err_lamp
);
  localparam int unsigned CNT_W = $clog2(STARTUP_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STARTUP_CYC - 1);
  localparam logic [1:0] MY_SEL = 2'(MOD_ID);
  // ****************************************
  // synchronisers for panel and processor inputs
  // ****************************************
  localparam int unsigned SW = 17;
  logic [SW-1:0] raw_in;
  logic [SW-1:0] syn;
  assign raw_in = {i_out_select, i_link_ready, i_ins_instr, i_ins_data, i_prog_wr_en,
                   i_jump_wr_en, i_step_adv, i_step_hold, i_start, i_halt_sw,
                   i_prog_halt_req, i_dev_err, i_int_err, i_mod_sel, i_disp_sel[1:0]};
  bit_sync #(.W(SW)) u_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_d     (raw_in),
    .o_q     (syn)
  );
  logic [7:0] code_s;
  logic       dsel2_s;
  bit_sync #(.W(9)) u_sync_code (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_d     ({i_code, i_disp_sel[2]}),
    .o_q     ({code_s, dsel2_s})
  );
  logic       sel_s, lrdy_s, ins_i_s, ins_d_s, pwe_s, jwe_s, adv_s, hold_s;
  logic       start_s, halt_s, phr_s, derr_s, ierr_s;
  logic [1:0] msel_s;
  logic [2:0] dsel_s;
  assign {sel_s, lrdy_s, ins_i_s, ins_d_s, pwe_s, jwe_s, adv_s, hold_s, start_s,
          halt_s, phr_s, derr_s, ierr_s, msel_s} = syn[SW-1:2];
  assign dsel_s = {dsel2_s, syn[1:0]};
  // ****************************************
  // link-clock receiver and its crossing
  // ****************************************
  logic [8:0] rx_char;
  logic       rx_tgl;
  logic       gate_l;
  logic       tgl_s;
  bit_sync #(.W(1)) u_gate_sync (
    .i_clk   (i_lclk),
    .i_rst_b (i_rst_b),
    .i_d     (o_clk_gate),
    .o_q     (gate_l)
  );
  link_rx u_rx (
    .i_lclk  (i_lclk),
    .i_rst_b (i_rst_b),
    .i_gate  (gate_l),
    .i_bit   (i_out_bit),
    .o_char  (rx_char),
    .o_tgl   (rx_tgl)
  );
  bit_sync #(.W(1)) u_tgl_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_d     (rx_tgl),
    .o_q     (tgl_s)
  );
  // ****************************************
  // state
  // ****************************************
  typedef struct packed
  {
    bufmod_pkg::out_state_t ost;
    bufmod_pkg::run_state_t rst;
    logic [CNT_W-1:0]       cnt;
    logic                   ready;
    logic                   gate;
    logic                   done;
    logic                   tgl_seen;
    logic [3:0][7:0]        msg;
    logic [1:0]             wr_ptr;
    logic [1:0]             rd_ptr;
    logic [7:0]             lchar;
    logic                   lstb;
    logic [7:0]             instr_lo;
    logic [7:0]             hold_reg;
    logic [7:0]             ptr;
    logic                   start_d;
    logic                   ins_i_d;
    logic                   ins_d_d;
    logic [8:0]             pcode;
    logic                   pwr;
    logic                   jwr;
    logic                   clr_lamp;
    logic                   pwr_lamp;
    logic                   start_lamp;
    logic                   halt_lamp;
    logic                   halt_sense;
    logic                   norm_lamp;
    logic [7:0]             disp;
    logic                   derr;
    logic                   ierr;
  } st_t;
  st_t st_q;
  st_t st_d;
  logic       mine;
  logic       eom_ok;
  logic       new_char;
  logic       start_p;
  logic [7:0] disp_v;
  assign mine     = (msel_s == MY_SEL);
  assign new_char = (tgl_s != st_q.tgl_seen);
  assign eom_ok   = new_char && (rx_char[7:0] == bufmod_pkg::EOM_CODE)
                    && (^rx_char == 1'b1);
  assign start_p  = start_s && !st_q.start_d;
  always_comb
  begin
    unique case (dsel_s)
      bufmod_pkg::DSP_INSTR: disp_v = st_q.instr_lo;
      bufmod_pkg::DSP_HOLD:  disp_v = st_q.hold_reg;
      bufmod_pkg::DSP_CHAR:  disp_v = st_q.lchar;
      bufmod_pkg::DSP_PTR:   disp_v = st_q.ptr;
      bufmod_pkg::DSP_CODE:  disp_v = code_s;
      default:               disp_v = bufmod_pkg::CODE_ZERO;
    endcase
  end
  always_comb
  begin
    st_d            = st_q;
    st_d.lstb       = 1'b0;
    st_d.start_d    = start_s;
    st_d.ins_i_d    = ins_i_s;
    st_d.ins_d_d    = ins_d_s;
    st_d.tgl_seen   = tgl_s;
    st_d.pcode      = {~^code_s, code_s};
    st_d.pwr        = pwe_s && mine;
    st_d.jwr        = jwe_s && mine;
    st_d.norm_lamp  = !(adv_s || hold_s);
    st_d.disp       = mine ? disp_v : bufmod_pkg::CODE_ZERO;
    st_d.derr       = derr_s;
    st_d.ierr       = ierr_s;
    st_d.halt_sense = halt_s;
    // panel inserts act on the selected module only
    if (mine && ins_i_s && !st_q.ins_i_d)
      st_d.instr_lo = code_s;
    if (mine && ins_d_s && !st_q.ins_d_d)
      st_d.hold_reg = code_s;
    // ****************************************
    // run control
    // ****************************************
    unique case (st_q.rst)
      bufmod_pkg::RUN_CLEAR:
      begin
        st_d.clr_lamp = 1'b1;
        if (st_q.cnt == CNT_LAST)
        begin
          st_d.rst      = bufmod_pkg::RUN_HALT;
          st_d.clr_lamp = 1'b0;
          st_d.pwr_lamp = 1'b1;
          st_d.cnt      = '0;
        end
        else
          st_d.cnt = st_q.cnt + CNT_W'(1);
      end
      bufmod_pkg::RUN_HALT:
      begin
        if (start_p)
          st_d.rst = (adv_s || hold_s) ? bufmod_pkg::RUN_STEP
                                       : bufmod_pkg::RUN_EXEC;
      end
      bufmod_pkg::RUN_EXEC:
      begin
        st_d.ptr = st_q.ptr + bufmod_pkg::PTR_ONE;
        if (halt_s && phr_s)
          st_d.rst = bufmod_pkg::RUN_HALT;
      end
      bufmod_pkg::RUN_STEP:
      begin
        // one operation, then halt; hold setting keeps pointer and instruction
        if (adv_s && !hold_s)
          st_d.ptr = st_q.ptr + bufmod_pkg::PTR_ONE;
        st_d.rst = bufmod_pkg::RUN_HALT;
      end
    endcase
    st_d.start_lamp = (st_d.rst == bufmod_pkg::RUN_EXEC)
                      || (st_d.rst == bufmod_pkg::RUN_STEP);
    st_d.halt_lamp  = (st_d.rst == bufmod_pkg::RUN_HALT);
    // ****************************************
    // output message sequence
    // ****************************************
    unique case (st_q.ost)
      bufmod_pkg::OUT_IDLE:
      begin
        if (st_q.rst != bufmod_pkg::RUN_CLEAR)
        begin
          st_d.ost   = bufmod_pkg::OUT_READY;
          st_d.ready = 1'b1;
        end
      end
      bufmod_pkg::OUT_READY:
      begin
        st_d.done = 1'b0;
        // processor may select only while ready is high
        if (sel_s)
        begin
          st_d.ost    = bufmod_pkg::OUT_MOVE;
          st_d.gate   = 1'b1;
          st_d.wr_ptr = '0;
        end
      end
      bufmod_pkg::OUT_MOVE:
      begin
        if (!sel_s)
        begin
          st_d.ost  = bufmod_pkg::OUT_READY;
          st_d.gate = 1'b0;
        end
        else if (new_char)
        begin
          st_d.msg[st_q.wr_ptr] = rx_char[7:0];
          st_d.wr_ptr = st_q.wr_ptr + 2'd1;
          if (eom_ok)
          begin
            st_d.done   = 1'b1;
            st_d.ready  = 1'b0;
            st_d.gate   = 1'b0;
            st_d.rd_ptr = '0;
            st_d.ost    = bufmod_pkg::OUT_SEND;
          end
        end
      end
      bufmod_pkg::OUT_SEND:
      begin
        // only the last four characters are held; longer messages wrap
        if (lrdy_s && !st_q.lstb)
        begin
          st_d.lchar  = st_q.msg[st_q.rd_ptr];
          st_d.lstb   = 1'b1;
          st_d.rd_ptr = st_q.rd_ptr + 2'd1;
          if (st_d.rd_ptr == st_q.wr_ptr)
          begin
            st_d.ost   = bufmod_pkg::OUT_READY;
            st_d.ready = 1'b1;
          end
        end
      end
    endcase
  end
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      st_q <= '0;
    else
      st_q <= st_d;
  end
  // ****************************************
  // assertions
  // ****************************************
  sequence s_eom_seen;
    (st_q.ost == bufmod_pkg::OUT_MOVE) && sel_s && eom_ok;
  endsequence
  a_done_drops_ready: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_eom_seen |=> (o_done && !o_out_ready))
    else $error("done did not drop ready");
  a_ready_on_drop: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ((st_q.ost == bufmod_pkg::OUT_MOVE) && !sel_s) |=> (o_out_ready && !o_clk_gate))
    else $error("ready lost on select drop");
  a_gate_on_select: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ((st_q.ost == bufmod_pkg::OUT_READY) && sel_s) |=> o_clk_gate)
    else $error("no clock gate after select");
  a_parity_odd: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (st_q.rst != bufmod_pkg::RUN_CLEAR) |-> (^o_panel_code == 1'b1))
    else $error("panel parity wrong");
  a_normal_lamp: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (adv_s || hold_s) |=> !o_normal_lamp)
    else $error("normal lamp in step");
  a_hold_no_advance: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ((st_q.rst == bufmod_pkg::RUN_STEP) && hold_s) |=> $stable(st_q.ptr))
    else $error("pointer moved in hold");
  a_step_halts: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (st_q.rst == bufmod_pkg::RUN_STEP) |=> ##1 o_halt_lamp)
    else $error("step did not halt");
  a_ins_data: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (mine && ins_d_s && !st_q.ins_d_d) |=> (st_q.hold_reg == $past(code_s)))
    else $error("insert data missed");
  a_lamps_excl: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !(o_clear_lamp && o_power_lamp))
    else $error("clear and power lamps both lit");
  a_write_gate: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !pwe_s |=> !o_prog_wr)
    else $error("program write without latch");
  assign o_out_ready    = st_q.ready;
  assign o_clk_gate     = st_q.gate;
  assign o_done         = st_q.done;
  assign o_link_char    = st_q.lchar;
  assign o_link_stb     = st_q.lstb;
  assign o_panel_code   = st_q.pcode;
  assign o_prog_wr      = st_q.pwr;
  assign o_jump_wr      = st_q.jwr;
  assign o_clear_lamp   = st_q.clr_lamp;
  assign o_power_lamp   = st_q.pwr_lamp;
  assign o_start_lamp   = st_q.start_lamp;
  assign o_halt_lamp    = st_q.halt_lamp;
  assign o_halt_sense   = st_q.halt_sense;
  assign o_normal_lamp  = st_q.norm_lamp;
  assign o_display      = st_q.disp;
  assign o_dev_err_lamp = st_q.derr;
  assign o_int_err_lamp = st_q.ierr;
endmodule : buffer_module_output_and_panel
`default_nettype wire

// *** logic/link_rx.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// serial receive on the link clock
// ****************************************
module link_rx (
  input  wire logic       i_lclk,
  input  wire logic       i_rst_b,
  input  wire logic       i_gate,
  input  wire logic       i_bit,
  output logic      [8:0] o_char,
  output logic            o_tgl
);
  typedef struct packed
  {
    logic [8:0] sh;
    logic [3:0] cnt;
    logic [8:0] chr;
    logic       tgl;
  } rx_t;
  rx_t st_q;
  rx_t st_d;
  // gate arrives synchronised from the main domain; bits shift in only while it is high
  always_comb
  begin
    st_d = st_q;
    if (!i_gate)
    begin
      st_d.cnt = bufmod_pkg::BITCNT_ZERO;
    end
    else
    begin
      st_d.sh = {i_bit, st_q.sh[8:1]};
      if (st_q.cnt == bufmod_pkg::BITCNT_LAST)
      begin
        st_d.cnt = bufmod_pkg::BITCNT_ZERO;
        st_d.chr = {i_bit, st_q.sh[8:1]};
        st_d.tgl = ~st_q.tgl;
      end
      else
        st_d.cnt = st_q.cnt + bufmod_pkg::BITCNT_ONE;
    end
  end
  always_ff @(posedge i_lclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      st_q <= '0;
    else
      st_q <= st_d;
  end
  assign o_char = st_q.chr;
  assign o_tgl  = st_q.tgl;
endmodule : link_rx
`default_nettype wire
